// ### hdl/port_strap_consts.svh
`ifndef PORT_STRAP_CONSTS_SVH
`define PORT_STRAP_CONSTS_SVH

// ==========================================================================
// Register port geometry
`define PSC_ADDR_W          8
`define PSC_DATA_W          32

// ==========================================================================
// Register byte offsets
`define PSC_REG_CONFIG      8'h00
`define PSC_REG_PRESENCE    8'h04
`define PSC_REG_L1_CTRL     8'h08
`define PSC_REG_LINK_STATUS 8'h0C

// ==========================================================================
// Field positions of the configuration register
`define PSC_CFG_VC1         0
`define PSC_CFG_RXPOL_DIS   1
`define PSC_CFG_PL_LARGE    2
`define PSC_CFG_SLOT_CLK    3
`define PSC_CFG_SEL         4
`define PSC_CFG_SLOT_LSB    8
`define PSC_CFG_MPS_LSB     12

// ==========================================================================
// Field positions of the link status register
`define PSC_ST_PIN_LSB      0
`define PSC_ST_L1_LSB       4
`define PSC_ST_REFCLK_LSB   8
`define PSC_ST_PLL_LSB      12

// ==========================================================================
// Max payload capability encodings
`define PSC_MPS_256         3'h1
`define PSC_MPS_512         3'h2
`define PSC_MPS_W           3

// ==========================================================================
// Reset value and port counts
`define PSC_L1_CTRL_RESET   4'h0
`define PSC_PORTS           4
`define PSC_DS_PORTS        3

// ==========================================================================
// PLL settle time after the reference clock returns
`define PSC_CLOCK_NS        4
`define PSC_PLL_SETTLE_NS   200
`define PSC_PLL_SETTLE_CYC  ((`PSC_PLL_SETTLE_NS + `PSC_CLOCK_NS - 1) / `PSC_CLOCK_NS)
`define PSC_CNT_W           8

`endif

// ### hdl/port_strap_pkg.sv
package port_strap_pkg;

  // ========================================================================
  // Captured strap values
  typedef struct packed {
    logic       vc1;
    logic       rx_pol_dis;
    logic       pl_large;
    logic       slot_clk;
    logic [2:0] slot_wired;
    logic       sel;
  } strap_t;

  // ========================================================================
  // Per port clock request sequencer
  typedef enum logic [1:0] {
    CR_ACTIVE,
    CR_RELEASE,
    CR_L1,
    CR_EXIT
  } clkreq_state_t;

  typedef struct packed {
    clkreq_state_t st;
    logic [7:0]    cnt;
    logic          pin_out;
    logic          pin_oe;
    logic          refclk_en;
    logic          pll_en;
    logic          in_l1;
  } clkreq_reg_t;

  // ========================================================================
  // Dual-use pin group
  typedef struct packed {
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
  } dual_pin_t;

  // ========================================================================
  // Main block state
  typedef struct packed {
    strap_t      straps;
    logic        vc1_en;
    logic        vc0_shared;
    logic        rxpol_det_en;
    logic [2:0]  mps_code;
    logic [2:0]  present;
    logic        slot_refclk;
    logic [2:0]  slot_conn;
    logic [3:0]  l1_ctrl;
    logic [31:0] rdata;
  } cfg_reg_t;

endpackage

// ### hdl/clkreq_port.sv
`timescale 1ns/1ns
`default_nettype none
`include "port_strap_consts.svh"

module clkreq_port (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic status_mode,
  input  wire logic status_bit,
  input  wire logic l1_request,
  input  wire logic pin_in,
  output logic      pin_out,
  output logic      pin_oe,
  output logic      refclk_en,
  output logic      pll_en,
  output logic      in_l1
);

  port_strap_pkg::clkreq_reg_t s_q;
  port_strap_pkg::clkreq_reg_t s_d;

  localparam logic [`PSC_CNT_W-1:0] SETTLE = `PSC_CNT_W'(`PSC_PLL_SETTLE_CYC);

  // ========================================================================
  // Sequencer
  always_comb begin
    s_d = s_q;
    if (!reset_n) begin
      s_d.st        = port_strap_pkg::CR_ACTIVE;
      s_d.cnt       = '0;
      s_d.pin_out   = 1'b0;
      s_d.pin_oe    = 1'b0;
      s_d.refclk_en = 1'b1;
      s_d.pll_en    = 1'b1;
      s_d.in_l1     = 1'b0;
    end else if (status_mode) begin
      // Pin is a plain push-pull status output; clocks stay on
      s_d.st        = port_strap_pkg::CR_ACTIVE;
      s_d.pin_out   = status_bit;
      s_d.pin_oe    = 1'b1;
      s_d.refclk_en = 1'b1;
      s_d.pll_en    = 1'b1;
      s_d.in_l1     = 1'b0;
    end else begin
      // Clock request is open drain and active low
      s_d.pin_out = 1'b0;
      case (s_q.st)
        port_strap_pkg::CR_ACTIVE: begin
          s_d.pin_oe = 1'b1;
          if (l1_request) begin
            s_d.st     = port_strap_pkg::CR_RELEASE;
            s_d.pin_oe = 1'b0;
          end
        end
        port_strap_pkg::CR_RELEASE: begin
          if (!l1_request) begin
            s_d.st     = port_strap_pkg::CR_ACTIVE;
            s_d.pin_oe = 1'b1;
          end else if (pin_in) begin
            s_d.st        = port_strap_pkg::CR_L1;
            s_d.refclk_en = 1'b0;
            s_d.pll_en    = 1'b0;
            s_d.in_l1     = 1'b1;
          end
        end
        port_strap_pkg::CR_L1: begin
          if (!pin_in || !l1_request) begin
            s_d.st        = port_strap_pkg::CR_EXIT;
            s_d.pin_oe    = 1'b1;
            s_d.refclk_en = 1'b1;
            s_d.cnt       = SETTLE;
          end
        end
        port_strap_pkg::CR_EXIT: begin
          if (s_q.cnt <= `PSC_CNT_W'(1)) begin
            s_d.st     = port_strap_pkg::CR_ACTIVE;
            s_d.cnt    = '0;
            s_d.pll_en = 1'b1;
            s_d.in_l1  = 1'b0;
          end else begin
            s_d.cnt = s_q.cnt - `PSC_CNT_W'(1);
          end
        end
        default: begin
          s_d.st = port_strap_pkg::CR_ACTIVE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    s_q <= s_d;
  end

  assign pin_out   = s_q.pin_out;
  assign pin_oe    = s_q.pin_oe;
  assign refclk_en = s_q.refclk_en;
  assign pll_en    = s_q.pll_en;
  assign in_l1     = s_q.in_l1;

endmodule

`default_nettype wire

// ### hdl/port_strap_config.sv
`timescale 1ns/1ns
`default_nettype none
`include "port_strap_consts.svh"

module port_strap_config (
  input  wire logic                   clock,
  input  wire logic                   reset_n,
  // Strap inputs
  input  wire logic                   vc1_strap,
  input  wire logic                   rx_polarity_detect_disable,
  input  wire logic                   max_payload_large_select,
  input  wire logic [2:0]             downstream_presence_n,
  input  wire logic                   common_slot_refclk,
  input  wire logic [2:0]             slot_implemented_per_port,
  input  wire logic                   substate_or_status_select,
  // Core side
  input  wire logic [3:0]             port_state_indicator,
  input  wire logic [3:0]             core_l1_request,
  // Dual-use pins
  input  wire logic [3:0]             dual_pin_in,
  output logic [3:0]                  dual_pin_out,
  output logic [3:0]                  dual_pin_oe,
  // Applied settings
  output logic                        vc1_enable,
  output logic                        vc0_uses_vc1_buffers,
  output logic                        rx_polarity_detect_enable,
  output logic [2:0]                  max_payload_code,
  output logic [2:0]                  device_present,
  output logic                        slot_uses_platform_refclk,
  output logic [2:0]                  slot_connected,
  output logic                        status_mode,
  output logic [3:0]                  refclk_enable,
  output logic [3:0]                  pll_enable,
  output logic [3:0]                  l1_substate,
  // Register port
  input  wire logic [`PSC_ADDR_W-1:0] reg_addr,
  input  wire logic [`PSC_DATA_W-1:0] reg_wdata,
  input  wire logic                   reg_write,
  input  wire logic                   reg_read,
  output logic [`PSC_DATA_W-1:0]      reg_rdata
);

  port_strap_pkg::cfg_reg_t  c_q;
  port_strap_pkg::cfg_reg_t  c_d;
  port_strap_pkg::dual_pin_t pins;
  logic [3:0]                l1_req;

  // ========================================================================
  // Register read decode
  function automatic logic [`PSC_DATA_W-1:0] read_mux(
    input logic [`PSC_ADDR_W-1:0] addr,
    input port_strap_pkg::cfg_reg_t c,
    input logic [3:0] pin_lvl,
    input logic [3:0] l1s,
    input logic [3:0] rce,
    input logic [3:0] plle
  );
    logic [`PSC_DATA_W-1:0] v;
    v = '0;
    case (addr)
      `PSC_REG_CONFIG: begin
        v[`PSC_CFG_VC1]       = c.straps.vc1;
        v[`PSC_CFG_RXPOL_DIS] = c.straps.rx_pol_dis;
        v[`PSC_CFG_PL_LARGE]  = c.straps.pl_large;
        v[`PSC_CFG_SLOT_CLK]  = c.straps.slot_clk;
        v[`PSC_CFG_SEL]       = c.straps.sel;
        v[`PSC_CFG_SLOT_LSB +: `PSC_DS_PORTS] = c.straps.slot_wired;
        v[`PSC_CFG_MPS_LSB +: `PSC_MPS_W] = c.mps_code;
      end
      `PSC_REG_PRESENCE: begin
        v[`PSC_DS_PORTS-1:0] = c.present;
      end
      `PSC_REG_L1_CTRL: begin
        v[`PSC_PORTS-1:0] = c.l1_ctrl;
      end
      `PSC_REG_LINK_STATUS: begin
        v[`PSC_ST_PIN_LSB +: `PSC_PORTS]    = pin_lvl;
        v[`PSC_ST_L1_LSB +: `PSC_PORTS]     = l1s;
        v[`PSC_ST_REFCLK_LSB +: `PSC_PORTS] = rce;
        v[`PSC_ST_PLL_LSB +: `PSC_PORTS]    = plle;
      end
      default: begin
        v = '0;
      end
    endcase
    return v;
  endfunction

  // ========================================================================
  // Strap capture, setting decode and register file
  always_comb begin
    c_d = c_q;
    if (!reset_n) begin
      // Straps follow the pins for as long as reset is held
      c_d.straps.vc1        = vc1_strap;
      c_d.straps.rx_pol_dis = rx_polarity_detect_disable;
      c_d.straps.pl_large   = max_payload_large_select;
      c_d.straps.slot_clk   = common_slot_refclk;
      c_d.straps.slot_wired = slot_implemented_per_port;
      c_d.straps.sel        = substate_or_status_select;
      c_d.l1_ctrl           = `PSC_L1_CTRL_RESET;
      c_d.rdata             = '0;
    end else begin
      if (reg_write && reg_addr == `PSC_REG_L1_CTRL) begin
        c_d.l1_ctrl = reg_wdata[`PSC_PORTS-1:0];
      end
      c_d.rdata = reg_read ? read_mux(reg_addr, c_q, dual_pin_in, l1_substate,
                                      refclk_enable, pll_enable) : '0;
    end
    // Settings derive from the held strap copy, except presence, which follows its pins
    c_d.vc1_en       = c_d.straps.vc1;
    c_d.vc0_shared   = !c_d.straps.vc1;
    c_d.rxpol_det_en = !c_d.straps.rx_pol_dis;
    c_d.mps_code     = c_d.straps.pl_large ? `PSC_MPS_512 : `PSC_MPS_256;
    c_d.present      = ~downstream_presence_n;
    c_d.slot_refclk  = c_d.straps.slot_clk;
    c_d.slot_conn    = c_d.straps.slot_wired;
  end

  always_ff @(posedge clock) begin
    c_q <= c_d;
  end

  // ========================================================================
  // Dual-use pin sequencers, one per port
  genvar gi;
  generate
    for (gi = 0; gi < `PSC_PORTS; gi++) begin : g_port
      assign l1_req[gi] = c_q.l1_ctrl[gi] & core_l1_request[gi];

      clkreq_port u_clkreq (
        .clock       (clock),
        .reset_n     (reset_n),
        .status_mode (c_q.straps.sel),
        .status_bit  (port_state_indicator[gi]),
        .l1_request  (l1_req[gi]),
        .pin_in      (dual_pin_in[gi]),
        .pin_out     (pins.pin_out[gi]),
        .pin_oe      (pins.pin_oe[gi]),
        .refclk_en   (refclk_enable[gi]),
        .pll_en      (pll_enable[gi]),
        .in_l1       (l1_substate[gi])
      );
    end
  endgenerate

  // ========================================================================
  // Outputs
  assign dual_pin_out              = pins.pin_out;
  assign dual_pin_oe               = pins.pin_oe;
  assign vc1_enable                = c_q.vc1_en;
  assign vc0_uses_vc1_buffers      = c_q.vc0_shared;
  assign rx_polarity_detect_enable = c_q.rxpol_det_en;
  assign max_payload_code          = c_q.mps_code;
  assign device_present            = c_q.present;
  assign slot_uses_platform_refclk = c_q.slot_refclk;
  assign slot_connected            = c_q.slot_conn;
  assign status_mode               = c_q.straps.sel;
  assign reg_rdata                 = c_q.rdata;

endmodule

`default_nettype wire

// ### verif/strap_monitor.sv
`timescale 1ns/1ns
`default_nettype none
`include "port_strap_consts.svh"

module strap_monitor (
  input wire logic       clock,
  input wire logic       reset_n,
  input wire logic       vc1_strap,
  input wire logic       rx_polarity_detect_disable,
  input wire logic       max_payload_large_select,
  input wire logic [2:0] downstream_presence_n,
  input wire logic       common_slot_refclk,
  input wire logic [2:0] slot_implemented_per_port,
  input wire logic [3:0] port_state_indicator,
  input wire logic [3:0] core_l1_request,
  input wire logic [3:0] dual_pin_in,
  input wire logic [3:0] dual_pin_out,
  input wire logic [3:0] dual_pin_oe,
  input wire logic       vc1_enable,
  input wire logic       vc0_uses_vc1_buffers,
  input wire logic       rx_polarity_detect_enable,
  input wire logic [2:0] max_payload_code,
  input wire logic [2:0] device_present,
  input wire logic       slot_uses_platform_refclk,
  input wire logic [2:0] slot_connected,
  input wire logic       status_mode,
  input wire logic [3:0] refclk_enable,
  input wire logic [3:0] pll_enable,
  input wire logic [3:0] l1_substate,
  input wire logic       reg_write
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ==========================================================================
  // Strap decode, captured at the last reset edge; presence follows its pins
  a_vc1_apply: assert property ($rose(reset_n) |=>
    vc1_enable == $past(vc1_strap, 2) && vc0_uses_vc1_buffers == !$past(vc1_strap, 2))
    else $error("channel setting wrong");
  a_rxpol_apply: assert property ($rose(reset_n) |=>
    rx_polarity_detect_enable == !$past(rx_polarity_detect_disable, 2))
    else $error("polarity detect setting wrong");
  a_payload_apply: assert property ($rose(reset_n) |=> max_payload_code ==
    ($past(max_payload_large_select, 2) ? `PSC_MPS_512 : `PSC_MPS_256))
    else $error("payload code wrong");
  a_slot_apply: assert property ($rose(reset_n) |=>
    slot_connected == $past(slot_implemented_per_port, 2)
    && slot_uses_platform_refclk == $past(common_slot_refclk, 2))
    else $error("slot setting wrong");
  a_strap_hold: assert property ($past(reset_n, 2) |-> $stable(vc1_enable)
    && $stable(max_payload_code) && $stable(slot_connected) && $stable(status_mode))
    else $error("setting moved outside reset");
  a_presence_track: assert property ($past(reset_n) |->
    device_present == ~$past(downstream_presence_n))
    else $error("presence wrong");
  // ==========================================================================
  // Dual-use pins per port
  for (genvar i = 0; i < 4; i++) begin : g_port
    sequence s_released;
      !status_mode && !dual_pin_oe[i] && dual_pin_in[i] && !l1_substate[i];
    endsequence
    sequence s_wake;
      refclk_enable[i] && dual_pin_oe[i] && !pll_enable[i] ##49 !pll_enable[i]
      ##1 pll_enable[i] && !l1_substate[i];
    endsequence
    a_l1_entry: assert property (
      $past(reset_n) && core_l1_request[i] && !reg_write && !$past(reg_write) ##0 s_released
      |=> l1_substate[i] && !refclk_enable[i] && !pll_enable[i])
      else $error("L1 entry wrong");
    a_l1_exit: assert property (
      l1_substate[i] && !refclk_enable[i] && !dual_pin_in[i] |=> s_wake)
      else $error("L1 exit wrong");
    a_clkreq_drive: assert property (
      !status_mode && dual_pin_oe[i] |-> !dual_pin_out[i])
      else $error("clock request driven high");
    a_status_drive: assert property ($past(reset_n) && status_mode |->
      dual_pin_oe[i] && dual_pin_out[i] == $past(port_state_indicator[i]))
      else $error("status pin wrong");
  end
endmodule

bind port_strap_config strap_monitor u_mon (.*);
`default_nettype wire

// ### verif/slot_board.sv
`timescale 1ns/1ns
`default_nettype none

module slot_board (
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe,
  input  wire logic [3:0] want_clock,
  output logic      [3:0] pin_level
);
  // ==========================================================================
  // Pull-up line; device pulls low to ask for the clock, lets go to allow L1
  assign pin_level = (pin_oe & pin_out | ~pin_oe) & ~want_clock;
endmodule
`default_nettype wire

// ### verif/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "port_strap_consts.svh"

module testbench;
  logic       clock, reset_n, vc1_strap, rx_polarity_detect_disable, max_payload_large_select;
  logic       common_slot_refclk, substate_or_status_select, reg_write, reg_read;
  logic       vc1_enable, vc0_uses_vc1_buffers, rx_polarity_detect_enable, status_mode;
  logic       slot_uses_platform_refclk;
  logic [2:0] downstream_presence_n, slot_implemented_per_port, slot_connected;
  logic [2:0] max_payload_code, device_present;
  logic [3:0] port_state_indicator, core_l1_request, dual_pin_in, dual_pin_out, dual_pin_oe;
  logic [3:0] refclk_enable, pll_enable, l1_substate, want_clock;
  logic [7:0] reg_addr, straps;
  logic [31:0] reg_wdata, reg_rdata;
  int         mismatches, checked, n;

  assign {substate_or_status_select, slot_implemented_per_port, common_slot_refclk,
          max_payload_large_select, rx_polarity_detect_disable, vc1_strap} = straps;
  port_strap_config u_dut (.*);
  slot_board u_board (.pin_out(dual_pin_out), .pin_oe(dual_pin_oe),
                      .want_clock(want_clock), .pin_level(dual_pin_in));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // ==========================================================================
  // Access tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic boot(input logic [7:0] s);
    reset_n <= 1'b0;
    straps  <= s;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    #1;
  endtask
  task automatic await(input int sel);
    n = 1;
    while (((sel ? pll_enable[1] : l1_substate[1]) !== 1'b1) && n < 200) begin
      @(posedge clock);
      #1 n++;
    end
    if (n >= 200) begin
      mismatches++;
      wrap_up();
    end
  endtask
  task automatic wrap_up();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ==========================================================================
  // Tests
  initial begin
    downstream_presence_n = 3'h7;
    port_state_indicator = 4'h0;
    core_l1_request = 4'h0;
    want_clock = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    boot(8'h5F);
    chk({vc1_enable, vc0_uses_vc1_buffers, rx_polarity_detect_enable}, 3'h4);
    chk(max_payload_code, `PSC_MPS_512);
    chk({slot_uses_platform_refclk, slot_connected, status_mode}, 5'h1A);
    @(posedge clock);
    straps <= 8'hA0;
    downstream_presence_n <= 3'h2;
    repeat (2) @(posedge clock);
    #1 chk(device_present, 3'h5);
    rd(`PSC_REG_CONFIG, 32'h250F);
    rd(`PSC_REG_PRESENCE, 32'h5);
    wr(`PSC_REG_CONFIG, 32'h0);
    rd(`PSC_REG_CONFIG, 32'h250F);
    rd(8'h10, 32'h0);
    $display("test straps done");
    @(posedge clock);
    core_l1_request <= 4'hF;
    wr(`PSC_REG_L1_CTRL, 32'h2);
    rd(`PSC_REG_L1_CTRL, 32'h2);
    await(0);
    chk({refclk_enable, pll_enable, dual_pin_oe, dual_pin_out}, 16'hDDD0);
    rd(`PSC_REG_LINK_STATUS, 32'hDD22);
    @(posedge clock);
    want_clock <= 4'h2;
    @(posedge clock);
    #1 chk({refclk_enable[1], pll_enable[1], dual_pin_oe[1]}, 3'h5);
    await(1);
    chk(n, 51);
    chk(l1_substate, 4'h0);
    @(posedge clock);
    want_clock <= 4'h0;
    await(0);
    chk(l1_substate, 4'h2);
    wr(`PSC_REG_L1_CTRL, 32'h0);
    @(posedge clock);
    #1 chk({refclk_enable[1], pll_enable[1], dual_pin_oe[1]}, 3'h5);
    await(1);
    chk(n, 51);
    chk(l1_substate, 4'h0);
    $display("test clock request done");
    @(posedge clock);
    port_state_indicator <= 4'hA;
    boot(8'hA0);
    chk({vc1_enable, vc0_uses_vc1_buffers, rx_polarity_detect_enable}, 3'h3);
    chk(max_payload_code, `PSC_MPS_256);
    chk({slot_uses_platform_refclk, slot_connected, status_mode}, 5'h05);
    rd(`PSC_REG_CONFIG, 32'h1210);
    rd(`PSC_REG_L1_CTRL, 32'h0);
    chk({dual_pin_oe, dual_pin_out}, 8'hFA);
    @(posedge clock);
    port_state_indicator <= 4'h5;
    @(posedge clock);
    #1 chk(dual_pin_out, 4'h5);
    $display("test status done");
    wrap_up();
  end
endmodule
`default_nettype wire
